// ===== ssmo_defs.svh
// Constants for the skip/set memory-op execution block.
// Assumes inclusion by bare name from the package and modules.
`ifndef SSMO_DEFS_SVH
`define SSMO_DEFS_SVH

// ----------------------------------------
// Data and field widths
// ----------------------------------------
`define SSMO_DW 8
`define SSMO_BIT_W 3
`define SSMO_ADDR_W 8
`define SSMO_ONE 8'h01
`define SSMO_ALL_ONES 8'hFF
`define SSMO_ZERO 8'h00
// Carry flag values after a subtract
`define SSMO_C_NEG 1'b0
`define SSMO_C_POS 1'b1
// Reset values
`define SSMO_WREG_RST 8'h00
`define SSMO_FLAGS_RST 6'h00

`endif

// ===== ssmo_pkg.sv
// Types for the skip/set memory-op execution block.
// Assumes ssmo_defs.svh is on the include path.
`include "ssmo_defs.svh"

package ssmo_pkg;

    // ----------------------------------------
    // Operation codes from the decoder
    // ----------------------------------------
    typedef enum logic [3:0] {
        SSMO_OP_NONE = 4'h0,
        SSMO_OP_SUB_BORROW_MEM = 4'h1,
        SSMO_OP_DEC_SKIP = 4'h2,
        SSMO_OP_DEC_SKIP_WREG = 4'h3,
        SSMO_OP_INC_SKIP = 4'h4,
        SSMO_OP_INC_SKIP_WREG = 4'h5,
        SSMO_OP_SET_BYTE = 4'h6,
        SSMO_OP_SET_BIT = 4'h7,
        SSMO_OP_BIT_TEST_SKIP = 4'h8,
        SSMO_OP_NOP = 4'h9
    } ssmo_op_e;

    // ----------------------------------------
    // Decoded instruction and status flags
    // ----------------------------------------
    typedef struct packed {
        ssmo_op_e op;
        logic [`SSMO_BIT_W-1:0] bit_sel;
        logic [`SSMO_DW-1:0] operand;
    } ssmo_instr_s;

    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic signed_compare_flag;
        logic compare_zero_flag;
    } ssmo_flags_s;

    typedef struct packed {
        logic mem_we;
        logic [`SSMO_DW-1:0] mem_wdata;
        logic wreg_we;
        logic [`SSMO_DW-1:0] wreg_wdata;
        logic flags_we;
        logic skip;
    } ssmo_result_s;

endpackage

// ===== ssmo_alu.sv
// Combinational datapath for the skip/set memory-op group.
// Assumes operand, working register and carry are stable in the execute cycle.
`timescale 1ns/1ns
`include "ssmo_defs.svh"

module ssmo_alu (
    input wire ssmo_pkg::ssmo_instr_s instr_i,
    input wire logic [`SSMO_DW-1:0] working_register_i,
    input wire ssmo_pkg::ssmo_flags_s flags_i,
    output ssmo_pkg::ssmo_result_s result_o,
    output ssmo_pkg::ssmo_flags_s flags_o
);
    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    wire logic borrow_in = ~flags_i.carry_flag;
    wire logic [`SSMO_DW:0] sub_full = {1'b0, working_register_i}
        - {1'b0, instr_i.operand} - {8'h00, borrow_in};
    wire logic [4:0] sub_low = {1'b0, working_register_i[3:0]}
        - {1'b0, instr_i.operand[3:0]} - {4'h0, borrow_in};
    wire logic [`SSMO_DW-1:0] sub_res = sub_full[`SSMO_DW-1:0];
    wire logic sub_ovf = (working_register_i[7] ^ instr_i.operand[7])
        & (working_register_i[7] ^ sub_res[7]);
    wire logic [`SSMO_DW-1:0] dec_res = instr_i.operand - `SSMO_ONE;
    wire logic [`SSMO_DW-1:0] inc_res = instr_i.operand + `SSMO_ONE;
    wire logic [`SSMO_DW-1:0] bit_mask = `SSMO_ONE << instr_i.bit_sel;
    wire logic sel_bit = instr_i.operand[instr_i.bit_sel];
    wire logic is_dec = instr_i.op inside {ssmo_pkg::SSMO_OP_DEC_SKIP,
        ssmo_pkg::SSMO_OP_DEC_SKIP_WREG};
    wire logic is_inc = instr_i.op inside {ssmo_pkg::SSMO_OP_INC_SKIP,
        ssmo_pkg::SSMO_OP_INC_SKIP_WREG};
    wire logic [`SSMO_DW-1:0] step_res = is_dec ? dec_res : inc_res;

    // ----------------------------------------
    // Result selection
    // ----------------------------------------
    always_comb begin
        result_o = '0;
        flags_o = flags_i;
        unique case (instr_i.op)
            ssmo_pkg::SSMO_OP_SUB_BORROW_MEM: begin
                result_o.mem_we = 1'b1;
                result_o.mem_wdata = sub_res;
                result_o.flags_we = 1'b1;
                flags_o.carry_flag = sub_full[`SSMO_DW] ? `SSMO_C_NEG : `SSMO_C_POS;
                flags_o.overflow_flag = sub_ovf;
                flags_o.zero_flag = (sub_res == `SSMO_ZERO);
                flags_o.half_carry_flag = ~sub_low[4];
                // Compare flags see the borrow-adjusted difference as signed
                flags_o.signed_compare_flag = sub_res[7] ^ sub_ovf;
                flags_o.compare_zero_flag = (sub_res == `SSMO_ZERO);
            end
            ssmo_pkg::SSMO_OP_DEC_SKIP, ssmo_pkg::SSMO_OP_INC_SKIP: begin
                result_o.mem_we = 1'b1;
                result_o.mem_wdata = step_res;
                result_o.skip = (step_res == `SSMO_ZERO);
            end
            ssmo_pkg::SSMO_OP_DEC_SKIP_WREG, ssmo_pkg::SSMO_OP_INC_SKIP_WREG: begin
                result_o.wreg_we = 1'b1;
                result_o.wreg_wdata = step_res;
                result_o.skip = (step_res == `SSMO_ZERO);
            end
            ssmo_pkg::SSMO_OP_SET_BYTE: begin
                result_o.mem_we = 1'b1;
                result_o.mem_wdata = `SSMO_ALL_ONES;
            end
            ssmo_pkg::SSMO_OP_SET_BIT: begin
                result_o.mem_we = 1'b1;
                result_o.mem_wdata = instr_i.operand | bit_mask;
            end
            ssmo_pkg::SSMO_OP_BIT_TEST_SKIP: begin
                result_o.skip = sel_bit;
            end
            default: begin
                result_o = '0;
            end
        endcase
    end
endmodule

// ===== ssmo_exec.sv
// Execute stage for the skip/set memory-op instruction group.
// Assumes the fetch stage presents one decoded instruction per cycle
// with its data-memory operand already read, and retires pc on advance.
// There is no forwarding: a word that reads a location written by the word
// just before it sees the stale value, so the fetch stage must space them.
`timescale 1ns/1ns
`include "ssmo_defs.svh"

// Overview of operation
// - Subtract with borrow, store, carry means not-negative
// - Subtract updates all six status flags
// - Decrement memory, skip when result zero
// - Taken skip costs one extra dummy cycle
// - Decrement into working register, memory unchanged
// - Byte set writes all ones, flags kept
// - Bit set forces one bit, rest kept
// - Increment memory, skip on wrap to zero
// - Increment into working register, memory unchanged
// - Bit test skips when selected bit set

module ssmo_exec (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire ssmo_pkg::ssmo_instr_s instr_i,
    input wire logic [`SSMO_ADDR_W-1:0] mem_addr_i,
    output logic mem_we_o,
    output logic [`SSMO_ADDR_W-1:0] mem_waddr_o,
    output logic [`SSMO_DW-1:0] mem_wdata_o,
    output logic [`SSMO_DW-1:0] working_register_o,
    output ssmo_pkg::ssmo_flags_s flags_o,
    output logic pc_advance_o,
    output logic squash_o,
    output logic retire_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    // One dummy state is enough: a squashed word can never skip again
    typedef enum logic [0:0] {
        SSMO_ST_RUN = 1'b0,
        SSMO_ST_DUMMY = 1'b1
    } ssmo_state_e;

    ssmo_state_e state_q;
    ssmo_state_e state_d;
    logic [`SSMO_DW-1:0] wreg_q;
    logic [`SSMO_DW-1:0] wreg_d;
    ssmo_pkg::ssmo_flags_s flags_q;
    ssmo_pkg::ssmo_flags_s flags_d;
    logic mem_we_q;
    logic [`SSMO_ADDR_W-1:0] mem_waddr_q;
    logic [`SSMO_DW-1:0] mem_wdata_q;
    logic pc_adv_q;
    logic squash_q;
    logic retire_q;

    ssmo_pkg::ssmo_result_s alu_res;
    ssmo_pkg::ssmo_flags_s alu_flags;

    // The datapath is combinational; every result it makes lands in a flop below
    ssmo_alu u_alu (
        .instr_i(instr_i),
        .working_register_i(wreg_q),
        .flags_i(flags_q),
        .result_o(alu_res),
        .flags_o(alu_flags)
    );

    // ----------------------------------------
    // Decode of this cycle's action
    // ----------------------------------------
    // The instruction in the dummy slot is the one being skipped: it is
    // consumed as a no-op so none of its writes can land.
    wire logic in_dummy = (state_q == SSMO_ST_DUMMY);
    wire logic exec_live = instr_valid_i & ~in_dummy;
    // A squashed word never starts a skip of its own
    wire logic take_skip = exec_live & alu_res.skip;
    wire logic do_mem_we = exec_live & alu_res.mem_we;
    wire logic do_wreg_we = exec_live & alu_res.wreg_we;
    wire logic do_flags_we = exec_live & alu_res.flags_we;
    wire logic leave_dummy = in_dummy & instr_valid_i;

    // ----------------------------------------
    // Skip sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SSMO_ST_RUN: begin
                if (take_skip) begin
                    state_d = SSMO_ST_DUMMY;
                end
            end
            SSMO_ST_DUMMY: begin
                // Only leave once the squashed word has actually arrived
                if (leave_dummy) begin
                    state_d = SSMO_ST_RUN;
                end
            end
        endcase
    end

    assign wreg_d = do_wreg_we ? alu_res.wreg_wdata : wreg_q;
    assign flags_d = do_flags_we ? alu_flags : flags_q;

    // ----------------------------------------
    // Next values of the write port and pulses
    // ----------------------------------------
    // Address and data follow every word and only mem_we_d qualifies them,
    // which keeps the wide fields free of an enable multiplexer.
    wire logic mem_we_d = do_mem_we;
    wire logic [`SSMO_ADDR_W-1:0] mem_waddr_d = mem_addr_i;
    wire logic [`SSMO_DW-1:0] mem_wdata_d = alu_res.mem_wdata;
    // A squashed word still moves the program counter past itself
    wire logic pc_adv_d = instr_valid_i;
    wire logic squash_d = leave_dummy;
    wire logic retire_d = exec_live;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    // A reset inside the dummy slot drops the pending squash
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= SSMO_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Working register and status flags
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wreg_q <= `SSMO_WREG_RST;
        end else begin
            wreg_q <= wreg_d;
        end
    end

    // Only the subtract writes the flags; it also reads carry as its borrow
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            flags_q <= `SSMO_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------
    // Data-memory write port
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mem_we_q <= 1'b0;
        end else begin
            mem_we_q <= mem_we_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mem_waddr_q <= '0;
        end else begin
            mem_waddr_q <= mem_waddr_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mem_wdata_q <= `SSMO_ZERO;
        end else begin
            mem_wdata_q <= mem_wdata_d;
        end
    end

    // ----------------------------------------
    // Advance, squash and retire pulses
    // ----------------------------------------
    // Each pulse stands for one cycle after the word that it reports
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pc_adv_q <= 1'b0;
        end else begin
            pc_adv_q <= pc_adv_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            squash_q <= 1'b0;
        end else begin
            squash_q <= squash_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            retire_q <= 1'b0;
        end else begin
            retire_q <= retire_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Bare flops, so the fetch stage never sees a decode glitch
    assign mem_we_o = mem_we_q;
    assign mem_waddr_o = mem_waddr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign working_register_o = wreg_q;
    assign flags_o = flags_q;
    assign pc_advance_o = pc_adv_q;
    assign squash_o = squash_q;
    assign retire_o = retire_q;
endmodule

// ===== ssmo_exec_monitor.sv
// Port-level assertions for the skip/set memory-op execute stage.
// Assumes it is bound to ssmo_exec and that one word is presented per cycle.
`timescale 1ns/1ns
`include "ssmo_defs.svh"

module ssmo_exec_monitor (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire ssmo_pkg::ssmo_instr_s instr_i,
    input wire logic [`SSMO_ADDR_W-1:0] mem_addr_i,
    input wire logic mem_we_o,
    input wire logic [`SSMO_ADDR_W-1:0] mem_waddr_o,
    input wire logic [`SSMO_DW-1:0] mem_wdata_o,
    input wire logic [`SSMO_DW-1:0] working_register_o,
    input wire ssmo_pkg::ssmo_flags_s flags_o,
    input wire logic pc_advance_o,
    input wire logic squash_o,
    input wire logic retire_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence op_s(ssmo_pkg::ssmo_op_e o);
        instr_valid_i && instr_i.op == o ##1 retire_o;
    endsequence
    // Skip seen only with a gap; for back-to-back words word_adv_a checks one advance and retire or squash, not the skip
    property skip_p(logic c);
        c ##1 retire_o && !instr_valid_i ##1 instr_valid_i |=> squash_o;
    endproperty
    squash_quiet_a: assert property (squash_o |-> !mem_we_o && !retire_o)
        else $error("squashed word wrote or retired");
    word_adv_a: assert property (instr_valid_i |=> pc_advance_o && retire_o != squash_o)
        else $error("accepted word not advanced exactly once");
    set_byte_a: assert property (op_s(ssmo_pkg::SSMO_OP_SET_BYTE)
        |-> mem_we_o && mem_wdata_o == 8'hFF && $stable(flags_o)) else $error("byte set wrong");
    set_bit_a: assert property (op_s(ssmo_pkg::SSMO_OP_SET_BIT)
        |-> mem_wdata_o == ($past(instr_i.operand) | (8'h01 << $past(instr_i.bit_sel))))
        else $error("bit set wrong");
    dec_mem_a: assert property (op_s(ssmo_pkg::SSMO_OP_DEC_SKIP)
        |-> mem_we_o && mem_wdata_o == $past(instr_i.operand) - 8'h01 && $stable(flags_o))
        else $error("decrement to memory wrong");
    dec_wreg_a: assert property (op_s(ssmo_pkg::SSMO_OP_DEC_SKIP_WREG)
        |-> !mem_we_o && working_register_o == $past(instr_i.operand) - 8'h01)
        else $error("decrement to working register wrong");
    inc_wreg_a: assert property (op_s(ssmo_pkg::SSMO_OP_INC_SKIP_WREG)
        |-> !mem_we_o && working_register_o == $past(instr_i.operand) + 8'h01)
        else $error("increment to working register wrong");
    dec_skip_a: assert property (skip_p(instr_valid_i && instr_i.operand == 8'h01
        && instr_i.op == ssmo_pkg::SSMO_OP_DEC_SKIP)) else $error("zero decrement not skipped");
    bit_skip_a: assert property (skip_p(instr_valid_i && instr_i.operand[instr_i.bit_sel]
        && instr_i.op == ssmo_pkg::SSMO_OP_BIT_TEST_SKIP)) else $error("bit test not skipped");
    sub_diff_a: assert property (op_s(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM)
        |-> mem_wdata_o == $past(working_register_o) - $past(instr_i.operand)
        - {7'h00, !$past(flags_o.carry_flag)} && flags_o.zero_flag == (mem_wdata_o == 8'h00))
        else $error("subtract with borrow wrong");
    cover property (squash_o);
    cover property (op_s(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM));
    cover property (op_s(ssmo_pkg::SSMO_OP_BIT_TEST_SKIP));
endmodule

bind ssmo_exec ssmo_exec_monitor u_mon (.mclk_i(mclk_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .mem_addr_i(mem_addr_i),
    .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
    .working_register_o(working_register_o), .flags_o(flags_o),
    .pc_advance_o(pc_advance_o), .squash_o(squash_o), .retire_o(retire_o));

// ===== skip_set_memory_ops_test.sv
// Directed testbench for the skip/set memory-op execute stage.
// Assumes the design files and the bound monitor are compiled first.
`timescale 1ns/1ns
`include "ssmo_defs.svh"

module skip_set_memory_ops_test;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic instr_valid_i = 1'b0;
    ssmo_pkg::ssmo_instr_s instr_i = '0;
    logic [`SSMO_ADDR_W-1:0] mem_addr_i = '0;
    logic mem_we_o, squash_o, retire_o, pc_advance_o;
    logic [`SSMO_ADDR_W-1:0] mem_waddr_o;
    logic [7:0] mem_wdata_o, working_register_o;
    ssmo_pkg::ssmo_flags_s flags_o;
    int n_errors = 0;
    int checks = 0;
    ssmo_exec u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .mem_addr_i(mem_addr_i), .mem_we_o(mem_we_o),
        .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
        .working_register_o(working_register_o), .flags_o(flags_o),
        .pc_advance_o(pc_advance_o), .squash_o(squash_o), .retire_o(retire_o));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One idle cycle between words keeps the operand free of write-back hazards
    task automatic go(input ssmo_pkg::ssmo_op_e op, input logic [2:0] b, input logic [7:0] d,
                      input logic we, input logic [7:0] wd, input logic sq);
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        instr_i <= '{op: op, bit_sel: b, operand: d};
        mem_addr_i <= d ^ 8'h5A;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        #1;
        chk("pc_advance", {7'h00, pc_advance_o}, 8'h01);
        chk("squash", {7'h00, squash_o}, {7'h00, sq});
        chk("retire", {7'h00, retire_o}, {7'h00, !sq});
        chk("mem_we", {7'h00, mem_we_o}, {7'h00, we});
        if (we) chk("wdata", mem_wdata_o, wd);
        if (we) chk("waddr", mem_waddr_o, d ^ 8'h5A);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sub;
        go(ssmo_pkg::SSMO_OP_INC_SKIP_WREG, 3'h0, 8'h2F, 1'b0, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM, 3'h0, 8'h10, 1'b1, 8'h1F, 1'b0);
        chk("carry", {7'h00, flags_o.carry_flag}, 8'h01);
        go(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM, 3'h0, 8'h1F, 1'b1, 8'h11, 1'b0);
        go(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM, 3'h0, 8'h40, 1'b1, 8'hF0, 1'b0);
        chk("flags", {2'h0, flags_o}, 8'h0A);
        go(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM, 3'h0, 8'h2F, 1'b1, 8'h00, 1'b0);
        chk("flags", {2'h0, flags_o}, 8'h15);
        go(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM, 3'h0, 8'hB0, 1'b1, 8'h80, 1'b0);
        chk("flags_ovf", {2'h0, flags_o}, 8'h28);
        go(ssmo_pkg::SSMO_OP_SUB_BORROW_MEM, 3'h0, 8'h2F, 1'b1, 8'h00, 1'b0);
    endtask
    task automatic t_wreg;
        go(ssmo_pkg::SSMO_OP_INC_SKIP_WREG, 3'h0, 8'h4F, 1'b0, 8'h00, 1'b0);
        chk("wreg", working_register_o, 8'h50);
        go(ssmo_pkg::SSMO_OP_INC_SKIP_WREG, 3'h0, 8'hFF, 1'b0, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_SET_BYTE, 3'h0, 8'h33, 1'b0, 8'h00, 1'b1);
        go(ssmo_pkg::SSMO_OP_DEC_SKIP_WREG, 3'h0, 8'h02, 1'b0, 8'h00, 1'b0);
        chk("wreg", working_register_o, 8'h01);
        go(ssmo_pkg::SSMO_OP_DEC_SKIP_WREG, 3'h0, 8'h01, 1'b0, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_INC_SKIP_WREG, 3'h0, 8'h10, 1'b0, 8'h00, 1'b1);
        chk("wreg", working_register_o, 8'h00);
    endtask
    task automatic t_mem;
        go(ssmo_pkg::SSMO_OP_DEC_SKIP, 3'h0, 8'h05, 1'b1, 8'h04, 1'b0);
        go(ssmo_pkg::SSMO_OP_DEC_SKIP, 3'h0, 8'h01, 1'b1, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_SET_BIT, 3'h1, 8'h00, 1'b0, 8'h00, 1'b1);
        go(ssmo_pkg::SSMO_OP_INC_SKIP, 3'h0, 8'h41, 1'b1, 8'h42, 1'b0);
        go(ssmo_pkg::SSMO_OP_INC_SKIP, 3'h0, 8'hFF, 1'b1, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_SET_BYTE, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1);
        go(ssmo_pkg::SSMO_OP_SET_BYTE, 3'h0, 8'h12, 1'b1, 8'hFF, 1'b0);
        go(ssmo_pkg::SSMO_OP_SET_BIT, 3'h2, 8'h10, 1'b1, 8'h14, 1'b0);
        go(ssmo_pkg::SSMO_OP_SET_BIT, 3'h7, 8'h00, 1'b1, 8'h80, 1'b0);
        chk("flags", {2'h0, flags_o}, 8'h15);
    endtask
    task automatic t_bit;
        go(ssmo_pkg::SSMO_OP_BIT_TEST_SKIP, 3'h3, 8'h08, 1'b0, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_BIT_TEST_SKIP, 3'h2, 8'hFB, 1'b0, 8'h00, 1'b1);
        go(ssmo_pkg::SSMO_OP_BIT_TEST_SKIP, 3'h2, 8'hFB, 1'b0, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_SET_BYTE, 3'h0, 8'h05, 1'b1, 8'hFF, 1'b0);
        chk("flags", {2'h0, flags_o}, 8'h15);
    endtask
    // A reset in the dummy slot must drop the pending squash
    task automatic t_rst;
        go(ssmo_pkg::SSMO_OP_INC_SKIP_WREG, 3'h0, 8'h4F, 1'b0, 8'h00, 1'b0);
        go(ssmo_pkg::SSMO_OP_BIT_TEST_SKIP, 3'h0, 8'h01, 1'b0, 8'h00, 1'b0);
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        chk("rst_wreg", working_register_o, 8'h00);
        chk("rst_flags", {2'h0, flags_o}, 8'h00);
        chk("rst_pulses", {5'h00, mem_we_o, squash_o, retire_o}, 8'h00);
        go(ssmo_pkg::SSMO_OP_SET_BYTE, 3'h0, 8'h21, 1'b1, 8'hFF, 1'b0);
        go(ssmo_pkg::SSMO_OP_NOP, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0);
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_sub;
        t_wreg;
        t_mem;
        t_bit;
        t_rst;
        results;
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_errors++;
        results;
    end
endmodule
